// *** logic/dual_clock_fifo_16x5.sv ***
// Dual-clock first-in first-out store of 16 five-bit words
`timescale 1ns/1ps

// Notes on behaviour
// - Holds sixteen five-bit words, moved whole.
// - Word taken on either load strobe rising.
// - Read strobe idles high; rising removes head.
// - Room output high unless store is full.
// - Low pulse when last location becomes vacant.
// - Output valid needs data and strobe high.
// - Data outputs show the oldest stored word.
// - Data leaves with the polarity it entered.
// - Output enable low drives all data outputs.
// - Enable high floats data; status keeps working.
// - Flush falling edge empties store, valid low.
// - Flush leaves data output values untouched.
// - Either side runs from DC to 10 MHz.
module dual_clock_fifo_16x5 (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic write_strobe_a_i,
	input wire logic write_strobe_b_i,
	input wire fifo_word_pkg::word_t word_in_i,
	input wire logic read_strobe_i,
	input wire logic out_en_n_i,
	input wire logic flush_n_i,
	output logic room_available_o,
	output logic tail_vacant_pulse_n_o,
	output logic output_ready_o,
	output fifo_word_pkg::data_pins_s data_pins_o
);

	// ----------------------------------------------------------------
	// Pointer coding helpers
	// ----------------------------------------------------------------

	// Binary to gray, so only one bit moves per step across domains
	function automatic logic [4:0] bin2gray(input logic [4:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	// Gray back to binary
	function automatic logic [4:0] gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b = 5'h00;
		b[4] = g[4];
		for (int i = 3; i >= 0; i--)
		begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------

	// Written only from the link side; read on the core side once the
	// gray pointer says the slot is settled
	fifo_word_pkg::word_t mem [fifo_word_pkg::DEPTH];

	// Head pointer, and its gray copy registered for the link side
	logic [4:0] rptr;
	logic [4:0] rgray;

	// ----------------------------------------------------------------
	// Link side: load strobes and write pointer
	// ----------------------------------------------------------------

	logic sa_s1, sa_s2, sa_s3;
	logic sb_s1, sb_s2, sb_s3;
	fifo_word_pkg::word_t win_s1, win_s2;
	logic [4:0] wbin, wgray, next_wbin;
	logic [4:0] rg_s1, rg_s2, rbin_link;
	logic wr_edge, full_link, write_go;

	// rate set by link clock
	// Strobe pins pass two flops; a third holds the old level
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sa_s1 <= fifo_word_pkg::SYNC_HIGH_RESET;
			sa_s2 <= fifo_word_pkg::SYNC_HIGH_RESET;
			sa_s3 <= fifo_word_pkg::SYNC_HIGH_RESET;
			sb_s1 <= fifo_word_pkg::SYNC_HIGH_RESET;
			sb_s2 <= fifo_word_pkg::SYNC_HIGH_RESET;
			sb_s3 <= fifo_word_pkg::SYNC_HIGH_RESET;
		end
		else
		begin
			sa_s1 <= write_strobe_a_i;
			sa_s2 <= sa_s1;
			sa_s3 <= sa_s2;
			sb_s1 <= write_strobe_b_i;
			sb_s2 <= sb_s1;
			sb_s3 <= sb_s2;
		end
	end

	// Data pins ride the same two stages so they line up with strobes
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			win_s1 <= fifo_word_pkg::WORD_RESET;
			win_s2 <= fifo_word_pkg::WORD_RESET;
		end
		else
		begin
			win_s1 <= word_in_i;
			win_s2 <= win_s1;
		end
	end

	// Read pointer brought over from the core side
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rg_s1 <= fifo_word_pkg::PTR_RESET;
			rg_s2 <= fifo_word_pkg::PTR_RESET;
		end
		else
		begin
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
		end
	end

	// either strobe rising
	// A held-high strobe never rises, so it inhibits nothing itself
	assign wr_edge = (sa_s2 && !sa_s3) || (sb_s2 && !sb_s3);
	assign rbin_link = gray2bin(rg_s2);
	assign full_link = (5'(wbin - rbin_link) == fifo_word_pkg::FULL_COUNT);
	assign write_go = wr_edge && !full_link;
	assign next_wbin = write_go ? 5'(wbin + fifo_word_pkg::PTR_STEP) : wbin;

	// whole word written in one slot
	always_ff @(posedge link_clk_i)
	begin
		if (write_go)
		begin
			mem[wbin[fifo_word_pkg::ADDR_W-1:0]] <= win_s2;
		end
	end

	// Write pointer, kept in binary and gray
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wbin <= fifo_word_pkg::PTR_RESET;
			wgray <= fifo_word_pkg::PTR_RESET;
		end
		else
		begin
			wbin <= next_wbin;
			wgray <= bin2gray(next_wbin);
		end
	end

	// room flag from the link-side view
	// Frees up only after the read pointer crosses, a safe lag
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			room_available_o <= 1'h1;
		end
		else
		begin
			room_available_o <=
				(5'(next_wbin - rbin_link) != fifo_word_pkg::FULL_COUNT);
		end
	end

	// ----------------------------------------------------------------
	// Core side: read strobe, flush, enable
	// ----------------------------------------------------------------

	logic rs_s1, rs_s2, rs_s3;
	logic fl_s1, fl_s2, fl_s3;
	logic oe_s1, oe_s2;
	logic [4:0] wg_s1, wg_s2, wbin_core, next_rptr;
	logic head_valid, next_head_valid;
	logic read_edge, flush_fall, head_load;
	logic empty_core, full_core, full_prev;

	// Pins into the core pass two flops; read strobe and flush get a third that holds the old level
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rs_s1 <= fifo_word_pkg::SYNC_HIGH_RESET;
			rs_s2 <= fifo_word_pkg::SYNC_HIGH_RESET;
			rs_s3 <= fifo_word_pkg::SYNC_HIGH_RESET;
			fl_s1 <= fifo_word_pkg::SYNC_HIGH_RESET;
			fl_s2 <= fifo_word_pkg::SYNC_HIGH_RESET;
			fl_s3 <= fifo_word_pkg::SYNC_HIGH_RESET;
			oe_s1 <= fifo_word_pkg::SYNC_HIGH_RESET;
			oe_s2 <= fifo_word_pkg::SYNC_HIGH_RESET;
		end
		else
		begin
			rs_s1 <= read_strobe_i;
			rs_s2 <= rs_s1;
			rs_s3 <= rs_s2;
			fl_s1 <= flush_n_i;
			fl_s2 <= fl_s1;
			fl_s3 <= fl_s2;
			oe_s1 <= out_en_n_i;
			oe_s2 <= oe_s1;
		end
	end

	// Write pointer brought over from the link side
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wg_s1 <= fifo_word_pkg::PTR_RESET;
			wg_s2 <= fifo_word_pkg::PTR_RESET;
		end
		else
		begin
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
		end
	end

	assign read_edge = rs_s2 && !rs_s3;
	// flush acts on its falling edge only
	assign flush_fall = !fl_s2 && fl_s3;
	assign wbin_core = gray2bin(wg_s2);
	assign empty_core = (wbin_core == rptr);
	assign full_core =
		(5'(wbin_core - rptr) == fifo_word_pkg::FULL_COUNT);
	// head refills with no read strobe
	assign head_load = !flush_fall && !head_valid && !empty_core;

	// Head pointer and head flag; rptr names the word on show
	always_comb
	begin
		next_rptr = rptr;
		next_head_valid = head_valid;
		if (flush_fall)
		begin
			// drop every stored word at once
			next_rptr = wbin_core;
			next_head_valid = 1'h0;
		end
		else if (read_edge && head_valid)
		begin
			next_rptr = 5'(rptr + fifo_word_pkg::PTR_STEP);
			next_head_valid = 1'h0;
		end
		else if (head_load)
		begin
			next_head_valid = 1'h1;
		end
	end

	// Head state registers; a flush jump may move several gray bits,
	// so the link side can misjudge room for a moment after a flush
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rptr <= fifo_word_pkg::PTR_RESET;
			rgray <= fifo_word_pkg::PTR_RESET;
			head_valid <= 1'h0;
		end
		else
		begin
			rptr <= next_rptr;
			rgray <= bin2gray(next_rptr);
			head_valid <= next_head_valid;
		end
	end

	// oldest word to the data outputs
	// flush never touches the shown value
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_pins_o.data <= fifo_word_pkg::WORD_RESET;
		end
		else if (head_load)
		begin
			data_pins_o.data <= mem[rptr[fifo_word_pkg::ADDR_W-1:0]];
		end
	end

	// float when high; nothing else depends on it
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_pins_o.oe <= 1'h0;
		end
		else
		begin
			data_pins_o.oe <= !oe_s2;
		end
	end

	// valid needs a head word and strobe high
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			output_ready_o <= 1'h0;
		end
		else
		begin
			output_ready_o <= next_head_valid && rs_s2;
		end
	end

	// one-cycle low when last location empties
	// Fires on the full-to-not-full step, not on every idle cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			full_prev <= 1'h0;
			tail_vacant_pulse_n_o <= 1'h1;
		end
		else
		begin
			full_prev <= full_core;
			tail_vacant_pulse_n_o <= !(full_prev && !full_core);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	a_depth_bound:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		5'(wbin_core - rptr) <= fifo_word_pkg::FULL_COUNT)
		else $error("store holds more than sixteen words");
	a_write_taken:
	assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		wr_edge && !full_link |=> wbin == 5'($past(wbin) + 5'h01))
		else $error("strobe edge into room did not store a word");
	a_room_when_full:
	assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		full_link && !wr_edge |=> !room_available_o)
		else $error("room shown while store full");
	a_full_blocks_write:
	assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		wr_edge && full_link |=> $stable(wbin))
		else $error("write accepted into a full store");
	a_remove_head:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		read_edge && head_valid && !flush_fall
		|=> rptr == 5'($past(rptr) + 5'h01) && !head_valid)
		else $error("read edge did not remove the head word");
	a_ready_strobe_low:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!rs_s2 |=> !output_ready_o)
		else $error("output valid high while read strobe low");
	a_ready_has_data:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		output_ready_o |-> head_valid)
		else $error("output valid without a head word");
	a_head_order:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		head_load |=> data_pins_o.data == mem[4'($past(rptr))])
		else $error("head word is not the oldest stored word");
	a_ripple_fill:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!head_valid && !empty_core && !flush_fall
		|=> head_valid
		##1 (output_ready_o || !$past(rs_s2) || !head_valid))
		else $error("waiting word did not reach the head");
	a_drive_enable:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!oe_s2 [*2] |-> data_pins_o.oe)
		else $error("data outputs not driven under low enable");
	a_float_enable:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		oe_s2 [*2] |-> !data_pins_o.oe)
		else $error("data outputs driven under high enable");
	a_flush_empties:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flush_fall |=> !output_ready_o && !head_valid
			&& rptr == $past(wbin_core))
		else $error("flush did not empty the store");
	a_flush_keeps_data:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flush_fall |=> $stable(data_pins_o.data))
		else $error("flush changed the data outputs");
	a_vacant_pulse:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!tail_vacant_pulse_n_o |=> tail_vacant_pulse_n_o)
		else $error("vacant pulse longer than one cycle");
	a_vacant_cause:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(full_core) && !full_core |=> !tail_vacant_pulse_n_o)
		else $error("last location freed without a pulse");

endmodule // dual_clock_fifo_16x5

// *** logic/fifo_word_pkg.sv ***
// Shared constants and types for the 16 x 5 dual-clock word store
package fifo_word_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int WORD_W = 5;
	localparam int DEPTH = 16;
	localparam int ADDR_W = 4;
	localparam int PTR_W = 5;

	// Occupancy that marks the store as full
	localparam logic [4:0] FULL_COUNT = 5'h10;
	// Pointer step for one word
	localparam logic [4:0] PTR_STEP = 5'h01;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [4:0] PTR_RESET = 5'h00;
	localparam logic [4:0] WORD_RESET = 5'h00;
	localparam logic SYNC_HIGH_RESET = 1'h1;
	localparam logic SYNC_LOW_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	// Highest word rate on either side, in MHz
	localparam int MAX_RATE_MHZ = 10;
	// Least period between two strobes, in core cycles
	localparam int MIN_STROBE_CYCLES =
		(1000000 / MAX_RATE_MHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef logic [WORD_W-1:0] word_t;

	// Three-state data output group
	typedef struct packed {
		logic oe;
		word_t data;
	} data_pins_s;

endpackage

// *** testbench/fifo_peer.sv ***
// Producer and consumer model facing the word store
`timescale 1ns/1ps
module fifo_peer (
	input wire logic clk_i,
	input wire logic ready_i,
	output logic write_strobe_a_o,
	output logic write_strobe_b_o,
	output fifo_word_pkg::word_t word_o,
	output logic read_strobe_o
);
	// Phase of 600 ns: a write lands up to three link edges after
	// the rise, so each call returns only once its word is stored
	localparam int PHASE = 120;

	// Idle levels: every strobe high
	initial
	begin
		write_strobe_a_o = 1'h1;
		write_strobe_b_o = 1'h1;
		word_o = 5'h00;
		read_strobe_o = 1'h1;
	end

	task automatic put(input fifo_word_pkg::word_t w, input logic use_b);
		@(posedge clk_i);
		word_o <= w;
		if (use_b)
			write_strobe_b_o <= 1'h0;
		else
			write_strobe_a_o <= 1'h0;
		repeat (PHASE) @(posedge clk_i);
		write_strobe_a_o <= 1'h1;
		write_strobe_b_o <= 1'h1;
		repeat (PHASE) @(posedge clk_i);
		// Hold over: show the inverse so stale data is never trusted
		word_o <= ~w;
	endtask

	// unload strobe dips, rise removes head
	task automatic take(output logic ready_seen);
		@(posedge clk_i);
		read_strobe_o <= 1'h0;
		repeat (6) @(posedge clk_i);
		#1;
		ready_seen = ready_i;
		@(posedge clk_i);
		read_strobe_o <= 1'h1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // fifo_peer

// *** testbench/tb_top.sv ***
// Self-checking bench for the dual-clock word store
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("mismatch %s exp %h got %h", nm, exp, got); \
		end \
	end
module tb_top;
	logic clk = 1'h0;
	logic link_clk;
	logic rst_n;
	logic out_en_n;
	logic flush_n;
	logic sa, sb, rs, room, vac_n, ready, seen;
	fifo_word_pkg::word_t din, held, w;
	fifo_word_pkg::data_pins_s pins;
	fifo_word_pkg::word_t exp_q[$];
	logic [7:0] seed = 8'h07;
	int bad_count = 0;
	int checks_done = 0;
	int vac_cnt = 0;
	int cyc = 0;

	// ----------------------------------------------------------------
	// Clocks, unrelated in phase
	// ----------------------------------------------------------------
	always #2.5 clk = ~clk;
	initial
	begin
		link_clk = 1'h0;
		#13.3;
		forever #80 link_clk = ~link_clk;
	end

	fifo_peer peer (.clk_i(clk), .ready_i(ready), .write_strobe_a_o(sa),
		.write_strobe_b_o(sb), .word_o(din), .read_strobe_o(rs));

	dual_clock_fifo_16x5 dut (.clk_i(clk), .rst_n_i(rst_n),
		.link_clk_i(link_clk), .write_strobe_a_i(sa),
		.write_strobe_b_i(sb), .word_in_i(din), .read_strobe_i(rs),
		.out_en_n_i(out_en_n), .flush_n_i(flush_n),
		.room_available_o(room), .tail_vacant_pulse_n_o(vac_n),
		.output_ready_o(ready), .data_pins_o(pins));

	// Vacant pulses and run-time ceiling
	always @(posedge clk)
	begin
		cyc++;
		if (rst_n === 1'h1 && vac_n === 1'h0)
			vac_cnt++;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic wait_ready();
		for (int k = 0; k < 200; k++)
		begin
			@(posedge clk);
			#1;
			if (ready === 1'h1)
				break;
		end
		`CHK("ready", 1'h1, ready)
	endtask

	task automatic wrap_up();
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'h0;
		out_en_n = 1'h1;
		flush_n = 1'h1;
		// Hold reset over two link edges so both sides clear
		repeat (2) @(posedge link_clk);
		@(posedge clk);
		rst_n <= 1'h1;
		#1;
		`CHK("room", 1'h1, room)
		`CHK("ready", 1'h0, ready)
		repeat (70) @(posedge clk);
		// Fill with corners then random words, strobes alternating
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr_next(seed);
			w = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : seed[4:0];
			exp_q.push_back(w);
			peer.put(w, i[0]);
		end
		wait_ready();
		`CHK("room", 1'h0, room)
		`CHK("data", exp_q[0], pins.data)
		// Seventeenth word must be dropped
		peer.put(5'h15, 1'h0);
		out_en_n <= 1'h0;
		repeat (8) @(posedge clk);
		#1;
		`CHK("oe", 1'h1, pins.oe)
		// Drain, checking order and the dip of ready
		while (exp_q.size() > 0)
		begin
			w = exp_q.pop_front();
			`CHK("data", w, pins.data)
			peer.take(seen);
			`CHK("ready_low", 1'h0, seen)
			if (exp_q.size() > 0)
				wait_ready();
		end
		repeat (100) @(posedge clk);
		#1;
		`CHK("ready", 1'h0, ready)
		`CHK("room", 1'h1, room)
		`CHK("vacant", 1, vac_cnt)
		out_en_n <= 1'h1;
		repeat (8) @(posedge clk);
		#1;
		`CHK("oe", 1'h0, pins.oe)
		// Flush a partly filled store with outputs off
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr_next(seed);
			peer.put(seed[4:0], i[0]);
		end
		wait_ready();
		held = pins.data;
		flush_n <= 1'h0;
		repeat (10) @(posedge clk);
		flush_n <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
		`CHK("ready", 1'h0, ready)
		`CHK("data", held, pins.data)
		// Store works again after the flush
		seed = lfsr_next(seed);
		w = seed[4:0];
		peer.put(w, 1'h1);
		wait_ready();
		`CHK("data", w, pins.data)
		wrap_up();
	end
endmodule // tb_top
